// [tiop_pkg.sv]
/*
  constants, register map and carrier types for the timed i/o port unit.
  assumes a single 200 MHz core clock and a plain register port.
*/
package tiop_pkg;
  localparam int DATA_W      = 32;
  localparam int ADDR_W      = 8;
  localparam int CNT_W       = 16;
  localparam int NUM_CLKBLK  = 6;
  localparam int CORE_MHZ    = 200;
  localparam int REF_MHZ     = 100;
  localparam int REF_DIV_CYC = CORE_MHZ / REF_MHZ;
  localparam logic [7:0] REF_DIV_LIM = 8'(REF_DIV_CYC - 1);
  localparam int EV_W        = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COND   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TIME   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TSTAMP = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CLKCFG = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PORTST = 8'h24;

  // clkcfg write layout
  localparam int CLKCFG_IDX_LSB = 16;
  localparam int CLKCFG_EXT_BIT = 8;

  // status / mask bit positions
  localparam int ST_RX   = 0;
  localparam int ST_TX   = 1;
  localparam int ST_COND = 2;

  // width select codes: 1, 4, 8, 16, 32 bits
  localparam logic [2:0] WSEL_1  = 3'h0;
  localparam logic [2:0] WSEL_4  = 3'h1;
  localparam logic [2:0] WSEL_8  = 3'h2;
  localparam logic [2:0] WSEL_16 = 3'h3;
  localparam logic [2:0] WSEL_32 = 3'h4;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic       timed;
    logic       cond_neq;
    logic       cond_en;
    logic       strobe_out_en;
    logic       strobe_in_en;
    logic [2:0] width_sel;
    logic       open_drain;
    logic       dir_out;
    logic       enable;
  } tiop_ctrl_s;

  localparam tiop_ctrl_s CTRL_RST = '0;

  typedef struct packed {
    logic       ext_src;
    logic [7:0] div;
  } tiop_clkcfg_s;

  localparam tiop_clkcfg_s CLKCFG_RST = '0;

  typedef enum logic {TX_IDLE, TX_SHIFT} tiop_tx_e;
  typedef enum logic {RX_WAIT, RX_SHIFT} tiop_rx_e;
endpackage

// [tiop_port.sv]
/*
  timed i/o port unit: one port of selectable width 1..32 with serdes,
  transfer registers, 16-bit port counter, timestamp, wait condition,
  strobes, open-drain, pin sharing and six clock blocks.
  assumes pins, strobe and external clock inputs are synchronous to core_clk_i.
*/
// Functional notes
// - port widths 1, 4, 8, 16, 32; all pins of a port share one direction.
// - port drives pins high or low, or samples them, optionally after a condition.
// - every core access to the port completes in one cycle.
// - open-drain: zero drives low, one leaves the pin undriven; per port.
// - data passes through a serialiser plus transfer register.
// - a 16-bit port counter can time the transfer.
// - counter readable any time; transfers can wait for a future count.
// - counter value saved as timestamp on each transfer.
// - an enabled link sharing the pins disables the port's drive.
// - narrower enabled port wins shared pins; unshared pins stay usable.
// - port always works at its full width.
// - six clock blocks; block 0 is the 100 MHz reference, others programmable.
// - a clock block may take a 1-bit input as clock, optionally divided.
// - ports accept an input strobe and can produce an output strobe.
// - after reset the port uses clock block 0.
// - pin conditions and transfers become events for the scheduler.
// - while in reset every pin has its pull-down enabled.
`timescale 1ns/10ps
module tiop_port
  import tiop_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              nrst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [DATA_W-1:0] pin_i,
  output logic      [DATA_W-1:0] pin_o,
  output logic      [DATA_W-1:0] pin_oe_o,
  output logic                   pull_down_o,
  input  wire logic              ext_clk_i,
  input  wire logic              strobe_in_i,
  output logic                   strobe_out_o,
  input  wire logic              link_en_i,
  input  wire logic [DATA_W-1:0] narrow_claim_i,
  output logic                   event_o,
  output logic                   irq_o
);

  tiop_ctrl_s              ctrl_ff;
  tiop_clkcfg_s            clkcfg_ff [NUM_CLKBLK];
  logic [2:0]              clkidx_ff;
  logic [DATA_W-1:0]       cond_ff;
  logic [CNT_W-1:0]        time_ff;
  logic [CNT_W-1:0]        cnt_ff;
  logic [CNT_W-1:0]        tstamp_ff;
  logic [EV_W-1:0]         status_ff;
  logic [EV_W-1:0]         mask_ff;
  logic [DATA_W-1:0]       rdata_ff;
  logic                    ext_prev_ff;
  logic [NUM_CLKBLK-1:0]   tick_ff;
  tiop_tx_e                tx_st_ff;
  logic [DATA_W-1:0]       txbuf_ff;
  logic                    txv_ff;
  logic [DATA_W-1:0]       shreg_ff;
  logic [5:0]              shcnt_ff;
  tiop_rx_e                rx_st_ff;
  logic [DATA_W-1:0]       rxsh_ff;
  logic [5:0]              rxcnt_ff;
  logic [DATA_W-1:0]       rxbuf_ff;
  logic                    rxv_ff;
  logic [DATA_W-1:0]       pin_ff;
  logic [DATA_W-1:0]       pin_oe_ff;
  logic                    pd_ff;
  logic                    strobe_out_ff;
  logic                    event_ff;
  logic                    irq_ff;

  logic                    ext_rise;
  logic                    port_tick;
  logic [2:0]              lg;
  logic [5:0]              wbits;
  logic [5:0]              last_chunk;
  logic [DATA_W-1:0]       wmask;
  logic [DATA_W-1:0]       avail;
  logic                    time_ok;
  logic                    cond_met;
  logic                    rx_qual;
  logic [DATA_W-1:0]       rx_next;
  logic                    tx_load;
  logic                    rx_start;
  logic                    rx_done;
  logic [EV_W-1:0]         ev;
  logic                    wr_ctrl;
  logic                    wr_data;
  logic                    rd_data;

  assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
  assign wr_data = wr_i && (addr_i == OFS_DATA);
  assign rd_data = rd_i && (addr_i == OFS_DATA);

  // width decode: full width always, pins shared with others masked on drive
  always_comb begin
    case (ctrl_ff.width_sel)
      WSEL_1:  lg = 3'h0;
      WSEL_4:  lg = 3'h2;
      WSEL_8:  lg = 3'h3;
      WSEL_16: lg = 3'h4;
      default: lg = 3'h5;
    endcase
    wbits      = 6'h1 << lg;
    last_chunk = (6'h20 >> lg) - 6'h1;
    wmask      = (lg == 3'h5) ? {DATA_W{1'b1}} : ((32'h1 << wbits) - 32'h1);
    avail      = wmask & ~narrow_claim_i & {DATA_W{~link_en_i}};
  end

  // clock blocks
  assign ext_rise = ext_clk_i & ~ext_prev_ff;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_clk_i;
    end
  end

  for (genvar b = 0; b < NUM_CLKBLK; b++) begin : g_cb
    logic       src;
    logic [7:0] lim;
    logic [7:0] div_ff;
    always_comb begin
      if (b == 0) begin
        src = 1'b1;
        lim = REF_DIV_LIM;
      end else begin
        src = clkcfg_ff[b].ext_src ? ext_rise : 1'b1;
        lim = clkcfg_ff[b].div;
      end
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        div_ff     <= 8'h00;
        tick_ff[b] <= 1'b0;
      end else begin
        tick_ff[b] <= 1'b0;
        if (src) begin
          if (div_ff >= lim) begin
            div_ff     <= 8'h00;
            tick_ff[b] <= 1'b1;
          end else begin
            div_ff <= div_ff + 8'h01;
          end
        end
      end
    end
  end

  assign port_tick = ctrl_ff.enable && (ctrl_ff.clk_sel < 3'(NUM_CLKBLK)) && tick_ff[ctrl_ff.clk_sel];

  // port counter
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else if (port_tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  assign time_ok = !ctrl_ff.timed || (cnt_ff == time_ff);

  always_comb begin
    cond_met = 1'b1;
    if (ctrl_ff.cond_en) begin
      cond_met = ((pin_i & wmask) == (cond_ff & wmask)) ^ ctrl_ff.cond_neq;
    end
  end

  // output path
  assign tx_load = port_tick && ctrl_ff.dir_out && txv_ff && time_ok &&
                   (tx_st_ff == TX_IDLE || shcnt_ff == last_chunk);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txbuf_ff <= '0;
      txv_ff   <= 1'b0;
    end else if (wr_data) begin
      txbuf_ff <= wdata_i;
      txv_ff   <= 1'b1;
    end else if (tx_load) begin
      txv_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_st_ff <= TX_IDLE;
      shreg_ff <= '0;
      shcnt_ff <= '0;
    end else if (port_tick && ctrl_ff.dir_out) begin
      case (tx_st_ff)
        TX_IDLE: begin
          if (tx_load) begin
            shreg_ff <= txbuf_ff;
            shcnt_ff <= '0;
            tx_st_ff <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_load) begin
            shreg_ff <= txbuf_ff;
            shcnt_ff <= '0;
          end else if (shcnt_ff != last_chunk) begin
            shreg_ff <= shreg_ff >> wbits;
            shcnt_ff <= shcnt_ff + 6'h01;
          end else begin
            tx_st_ff <= TX_IDLE;
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // input path
  assign rx_qual  = port_tick && !ctrl_ff.dir_out && (!ctrl_ff.strobe_in_en || strobe_in_i);
  assign rx_start = rx_qual && (rx_st_ff == RX_WAIT) && time_ok && cond_met;
  assign rx_next  = (rxsh_ff >> wbits) | ((pin_i & wmask) << (6'h20 - wbits));
  assign rx_done  = (rx_start && last_chunk == 6'h00) ||
                    (rx_qual && rx_st_ff == RX_SHIFT && rxcnt_ff == last_chunk);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st_ff <= RX_WAIT;
      rxsh_ff  <= '0;
      rxcnt_ff <= '0;
    end else begin
      case (rx_st_ff)
        RX_WAIT: begin
          if (rx_start) begin
            rxsh_ff  <= rx_next;
            rxcnt_ff <= 6'h01;
            if (last_chunk != 6'h00) begin
              rx_st_ff <= RX_SHIFT;
            end
          end
        end
        RX_SHIFT: begin
          if (ctrl_ff.dir_out) begin
            rx_st_ff <= RX_WAIT;
          end else if (rx_qual) begin
            rxsh_ff  <= rx_next;
            rxcnt_ff <= rxcnt_ff + 6'h01;
            if (rxcnt_ff == last_chunk) begin
              rx_st_ff <= RX_WAIT;
            end
          end
        end
        default: rx_st_ff <= RX_WAIT;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rxbuf_ff <= '0;
      rxv_ff   <= 1'b0;
    end else if (rx_done) begin
      rxbuf_ff <= rx_next;
      rxv_ff   <= 1'b1;
    end else if (rd_data) begin
      rxv_ff <= 1'b0;
    end
  end

  // timestamp
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tstamp_ff <= '0;
    end else if (tx_load || rx_done) begin
      tstamp_ff <= cnt_ff;
    end
  end

  // pin drive
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_ff        <= '0;
      pin_oe_ff     <= '0;
      strobe_out_ff <= 1'b0;
      pd_ff         <= 1'b1;
    end else begin
      pd_ff <= 1'b0;
      if (ctrl_ff.enable && ctrl_ff.dir_out) begin
        if (ctrl_ff.open_drain) begin
          pin_ff    <= '0;
          pin_oe_ff <= ~shreg_ff & avail;
        end else begin
          pin_ff    <= shreg_ff & avail;
          pin_oe_ff <= avail;
        end
      end else begin
        pin_ff    <= '0;
        pin_oe_ff <= '0;
      end
      strobe_out_ff <= ctrl_ff.enable && ctrl_ff.dir_out && ctrl_ff.strobe_out_en &&
                       (tx_st_ff == TX_SHIFT) && !link_en_i;
    end
  end

  // events, status and interrupt
  assign ev[ST_RX]   = rx_done;
  assign ev[ST_TX]   = tx_load;
  assign ev[ST_COND] = rx_start && ctrl_ff.cond_en;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_ff <= '0;
      event_ff  <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      event_ff <= |ev;
      irq_ff   <= |(status_ff & mask_ff);
      if (wr_i && addr_i == OFS_STATUS) begin
        status_ff <= (status_ff & ~wdata_i[EV_W-1:0]) | ev;
      end else begin
        status_ff <= status_ff | ev;
      end
    end
  end

  // register writes
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_ff   <= CTRL_RST;
      cond_ff   <= '0;
      time_ff   <= '0;
      mask_ff   <= '0;
      clkidx_ff <= '0;
      for (int i = 0; i < NUM_CLKBLK; i++) begin
        clkcfg_ff[i] <= CLKCFG_RST;
      end
    end else if (wr_i) begin
      case (addr_i)
        OFS_CTRL: ctrl_ff <= tiop_ctrl_s'(wdata_i[$bits(tiop_ctrl_s)-1:0]);
        OFS_COND: cond_ff <= wdata_i;
        OFS_TIME: time_ff <= wdata_i[CNT_W-1:0];
        OFS_MASK: mask_ff <= wdata_i[EV_W-1:0];
        OFS_CLKCFG: begin
          clkidx_ff <= wdata_i[CLKCFG_IDX_LSB +: 3];
          if (wdata_i[CLKCFG_IDX_LSB +: 3] < 3'(NUM_CLKBLK)) begin
            clkcfg_ff[wdata_i[CLKCFG_IDX_LSB +: 3]] <= {wdata_i[CLKCFG_EXT_BIT], wdata_i[7:0]};
          end
        end
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= '0;
    end else if (rd_i) begin
      case (addr_i)
        OFS_CTRL:   rdata_ff <= 32'(ctrl_ff);
        OFS_DATA:   rdata_ff <= rxbuf_ff;
        OFS_COND:   rdata_ff <= cond_ff;
        OFS_TIME:   rdata_ff <= 32'(time_ff);
        OFS_COUNT:  rdata_ff <= 32'(cnt_ff);
        OFS_TSTAMP: rdata_ff <= 32'(tstamp_ff);
        OFS_CLKCFG: begin
          if (clkidx_ff < 3'(NUM_CLKBLK)) begin
            rdata_ff <= {13'h0, clkidx_ff, 7'h0, clkcfg_ff[clkidx_ff]};
          end else begin
            rdata_ff <= {13'h0, clkidx_ff, 16'h0};
          end
        end
        OFS_STATUS: rdata_ff <= 32'(status_ff);
        OFS_MASK:   rdata_ff <= 32'(mask_ff);
        OFS_PORTST: rdata_ff <= {28'h0, (rx_st_ff == RX_SHIFT), (tx_st_ff == TX_SHIFT), txv_ff, rxv_ff};
        default:    rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata_o      = rdata_ff;
  assign pin_o        = pin_ff;
  assign pin_oe_o     = pin_oe_ff;
  assign pull_down_o  = pd_ff;
  assign strobe_out_o = strobe_out_ff;
  assign event_o      = event_ff;
  assign irq_o        = irq_ff;

endmodule

// [tiop_port_chk.sv]
/*
  concurrent checks on the tiop_port pins and register port.
  assumes a single core clock; bound into every tiop_port.
*/
`timescale 1ns/10ps
module tiop_port_chk
  import tiop_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [DATA_W-1:0] pin_oe_o,
  input wire logic              pull_down_o,
  input wire logic              link_en_i,
  input wire logic [DATA_W-1:0] narrow_claim_i,
  input wire logic              event_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // two count reads two cycles apart
  sequence cnt_rd_s;
    rd_i && addr_i == OFS_COUNT;
  endsequence
  sequence cnt_pair_s;
    cnt_rd_s ##2 cnt_rd_s;
  endsequence

  pulldown_rel_a: assert property ($rose(nrst_i) |-> pull_down_o ##1 !pull_down_o)
    else $error("pull-down not released after reset");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside its cycle");
  unmapped_rd_a: assert property (rd_i && addr_i >= 8'h28 |=> rdata_o == '0)
    else $error("unmapped read not zero");
  count_step_a: assert property (cnt_pair_s |=> rdata_o[15:0] - $past(rdata_o[15:0], 2) <= 16'h1
    && rdata_o[31:16] == 16'h0)
    else $error("port counter step or width wrong");
  tstamp_w_a: assert property (rd_i && addr_i == OFS_TSTAMP |=> rdata_o[31:16] == 16'h0)
    else $error("timestamp wider than 16 bits");
  link_owns_a: assert property (link_en_i && $past(link_en_i) |-> pin_oe_o == '0)
    else $error("port drives pins owned by link");
  claim_mask_a: assert property (|(narrow_claim_i & $past(narrow_claim_i))
    |-> (pin_oe_o & narrow_claim_i & $past(narrow_claim_i)) == '0)
    else $error("wide port drives claimed pin");
  event_pulse_a: assert property (event_o |=> !event_o)
    else $error("event longer than one cycle");
endmodule

bind tiop_port tiop_port_chk u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .pin_oe_o(pin_oe_o), .pull_down_o(pull_down_o), .link_en_i(link_en_i),
  .narrow_claim_i(narrow_claim_i), .event_o(event_o));

// [tiop_pins_mdl.sv]
/*
  hardware on the pins: resolves pin levels, drives inputs and strobe,
  latches output data on the strobe, makes the external clock.
  assumes the bench changes drive values after a core clock edge.
*/
`timescale 1ns/10ps
module tiop_pins_mdl
  import tiop_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic [DATA_W-1:0] pin_o_i,
  input  wire logic [DATA_W-1:0] pin_oe_i,
  input  wire logic              pull_down_i,
  input  wire logic              strobe_out_i,
  input  wire logic [DATA_W-1:0] drv_val_i,
  input  wire logic [DATA_W-1:0] drv_en_i,
  input  wire logic              stb_req_i,
  output logic      [DATA_W-1:0] pin_i_o,
  output logic                   strobe_in_o,
  output logic                   ext_clk_o,
  output logic      [DATA_W-1:0] got_o
);
  logic [DATA_W-1:0] noise_ff = 32'h5a5a_a5a5;

  // floating pins never hold a level
  always @(posedge core_clk_i)
    noise_ff <= ~noise_ff;
  // device drive wins, released open-drain pins float
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drv_en_i & drv_val_i)
                 | (~pin_oe_i & ~drv_en_i & (pull_down_i ? '0 : noise_ff));
  assign strobe_in_o = stb_req_i;
  initial ext_clk_o = 1'b0;
  initial got_o = '0;
  // take data only while the strobe says so
  always @(posedge core_clk_i)
    if (strobe_out_i)
      got_o <= pin_i_o;

  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      ext_clk_o <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      ext_clk_o <= 1'b0;
      @(posedge core_clk_i);
    end
  endtask
endmodule

// [tb_timed_io_port_with_clock_blocks.sv]
/*
  self-checking bench for tiop_port: register tasks and directed tests.
  assumes tiop_pins_mdl and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
module tb_timed_io_port_with_clock_blocks
  import tiop_pkg::*;
;
  logic              core_clk_i = 1'b0;
  logic              nrst_i     = 1'b0;
  logic              wr = 1'b0, rd = 1'b0, link = 1'b0, stb = 1'b0;
  logic              pd, ext_clk, stb_in, sout, ev, irq;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, drv_val = '0, drv_en = '0, claim = '0;
  logic [DATA_W-1:0] pin_i, pin_o, pin_oe, rdata, got, v, c0, good, bad;
  int                errors = 0;
  int                n_compared = 0;
  int                n_ev = 0;
  int                e0 = 0;

  tiop_port dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .pull_down_o(pd),
    .ext_clk_i(ext_clk), .strobe_in_i(stb_in), .strobe_out_o(sout), .link_en_i(link),
    .narrow_claim_i(claim), .event_o(ev), .irq_o(irq));
  tiop_pins_mdl mdl (.core_clk_i(core_clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pull_down_i(pd),
    .strobe_out_i(sout), .drv_val_i(drv_val), .drv_en_i(drv_en), .stb_req_i(stb), .pin_i_o(pin_i),
    .strobe_in_o(stb_in), .ext_clk_o(ext_clk), .got_o(got));

  initial forever #2.5 core_clk_i = ~core_clk_i;

  // scheduler event pulses seen on the pin
  always @(posedge core_clk_i) begin
    if (ev) begin
      n_ev <= n_ev + 1;
    end
  end

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    @(negedge core_clk_i);
    d = rdata;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd_reg(a, v);
    chk(v, e);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic end_test(input string s);
    $display("test %s done, %0d mismatches so far", s, errors);
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #40000;
    errors++;
    test_done;
  end

  initial begin
    repeat (6) @(posedge core_clk_i);
    chk(DATA_W'(pd), 32'h1);
    nrst_i <= 1'b1;
    rd_chk(OFS_CTRL, '0);
    rd_chk(8'h40, '0);
    chk(DATA_W'(pd), '0);
    end_test("reset");
    wr_reg(OFS_CTRL, 32'h1);
    rd_reg(OFS_COUNT, c0);
    rd_reg(OFS_COUNT, v);
    repeat (16) @(posedge core_clk_i);
    rd_chk(OFS_COUNT, c0 + 32'd10);
    wr_reg(OFS_CLKCFG, 32'h0001_0101);
    wr_reg(OFS_CTRL, 32'h801);
    rd_reg(OFS_COUNT, c0);
    mdl.ext_edges(10);
    wait_cyc(4);
    rd_chk(OFS_COUNT, c0 + 32'd5);
    end_test("clock blocks");
    wr_reg(OFS_CTRL, 32'ha3);
    wr_reg(OFS_STATUS, 32'h7);
    wr_reg(OFS_MASK, 32'h2);
    e0 = n_ev;
    wr_reg(OFS_DATA, 32'hc3a5_0f96);
    wait_cyc(10);
    chk(pin_o, 32'hc3a5_0f96);
    chk(pin_oe, '1);
    chk(got, 32'hc3a5_0f96);
    chk(DATA_W'(irq), 32'h1);
    chk(32'(n_ev - e0), 32'h1);
    rd_chk(OFS_STATUS, 32'h2);
    wr_reg(OFS_STATUS, 32'h2);
    wr_reg(OFS_MASK, '0);
    wr_reg(OFS_CTRL, 32'h27);
    wr_reg(OFS_DATA, 32'h0000_ffff);
    wait_cyc(10);
    chk(DATA_W'(irq), '0);
    chk(pin_o, '0);
    chk(pin_oe, 32'hffff_0000);
    @(posedge core_clk_i);
    link <= 1'b1;
    wr_reg(OFS_DATA, 32'h0000_ffff);
    wait_cyc(10);
    chk(pin_oe, '0);
    @(posedge core_clk_i);
    link <= 1'b0;
    claim <= 32'h00ff_0000;
    wr_reg(OFS_DATA, 32'h0000_ffff);
    wait_cyc(10);
    chk(pin_oe, 32'hff00_0000);
    end_test("output");
    @(posedge core_clk_i);
    claim <= '0;
    wr_reg(OFS_CTRL, 32'h423);
    rd_reg(OFS_COUNT, c0);
    wr_reg(OFS_TIME, c0 + 32'd40);
    wr_reg(OFS_DATA, 32'h5555_aaaa);
    wait_cyc(100);
    chk(pin_o, 32'h5555_aaaa);
    rd_chk(OFS_TSTAMP, c0 + 32'd40);
    wr_reg(OFS_CTRL, 32'h1b);
    wr_reg(OFS_DATA, 32'h1234_abcd);
    wait_cyc(10);
    chk(pin_o, 32'h0000_1234);
    end_test("timed");
    for (int m = 0; m < 2; m++) begin
      good = m ? 32'h0f0f_0f0f : 32'h5a5a_5a5a;
      bad = m ? 32'h5a5a_5a5a : 32'h0f0f_0f0f;
      wr_reg(OFS_CTRL, m ? 32'h361 : 32'h161);
      wr_reg(OFS_COND, 32'h5a5a_5a5a);
      @(posedge core_clk_i);
      drv_en <= '1;
      drv_val <= good;
      rd_reg(OFS_DATA, v);
      wr_reg(OFS_STATUS, 32'h7);
      wait_cyc(10);
      rd_chk(OFS_PORTST, '0);
      @(posedge core_clk_i);
      stb <= 1'b1;
      drv_val <= bad;
      wait_cyc(10);
      rd_chk(OFS_PORTST, '0);
      @(posedge core_clk_i);
      drv_val <= good;
      wait_cyc(10);
      rd_chk(OFS_DATA, good);
      rd_chk(OFS_STATUS, 32'h5);
      @(posedge core_clk_i);
      stb <= 1'b0;
      drv_val <= bad;
    end
    end_test("input condition");
    @(posedge core_clk_i);
    drv_val <= 32'h0000_00a7;
    claim <= 32'h0000_00ff;
    wr_reg(OFS_CTRL, 32'h11);
    wait_cyc(24);
    rd_chk(OFS_DATA, 32'ha7a7_a7a7);
    end_test("serial input");
    test_done;
  end
endmodule
